// ===== hw/aer_pkg.sv
`default_nettype none

package aer_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] OFS_UNC_SEVERITY  = 12'h10C;
  localparam logic [11:0] OFS_COR_STATUS    = 12'h110;
  localparam logic [11:0] OFS_COR_MASK      = 12'h114;
  localparam logic [11:0] OFS_ADV_CAP_CTRL  = 12'h118;
  localparam logic [11:0] OFS_IRQ_STATUS    = 12'h140;
  localparam logic [11:0] OFS_IRQ_ENABLE    = 12'h144;

  // ****************************************************************
  // Reset values and writable-bit layouts
  // ****************************************************************
  localparam logic [31:0] SEV_RESET         = 32'h0003_0010;
  localparam logic [31:0] SEV_WRITABLE      = 32'h0017_F010;
  localparam logic [31:0] COR_STATUS_RESET  = 32'h0000_0000;
  localparam logic [31:0] COR_MASK_RESET    = 32'h0000_0000;
  localparam logic [31:0] COR_IMPL          = 32'h0000_11C1;
  localparam logic [31:0] UNC_IMPL          = 32'h0017_F010;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int COR_REPLAY_TIMEOUT   = 12;
  localparam int COR_REPLAY_ROLLOVER  = 8;
  localparam int COR_BAD_LINK_PACKET  = 7;
  localparam int COR_BAD_TRANSACTION  = 6;
  localparam int COR_RECEIVER_ERROR   = 0;
  localparam int PTR_MSB              = 4;
  localparam int CRC_CHECK_ENABLE     = 8;
  localparam int CRC_CHECK_CAPABLE    = 7;
  localparam int CRC_GEN_ENABLE       = 6;
  localparam int CRC_GEN_CAPABLE      = 5;

  // Interrupt status / enable layout
  localparam int IRQ_W                = 3;
  localparam int IRQ_COR              = 0;
  localparam int IRQ_NONFATAL         = 1;
  localparam int IRQ_FATAL            = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  localparam logic [1:0] REPLAY_NUM_TOP = 2'h3;
  localparam logic [1:0] REPLAY_NUM_BOT = 2'h0;

endpackage : aer_pkg

`default_nettype wire

// ===== hw/aer_first_bit.sv
`default_nettype none

// ****************************************************************
// Lowest set bit finder
// ****************************************************************
module aer_first_bit #(
  parameter int W  = 32,
  parameter int IW = 5
) (
  input  wire logic [W-1:0]  vec,
  output logic               found,
  output logic [IW-1:0]      index
);

  always_comb begin
    found = 1'b0;
    index = '0;
    // Scan downward so the lowest position is assigned last
    for (int i = W - 1; i >= 0; i--) begin
      if (vec[i]) begin
        found = 1'b1;
        index = IW'(i);
      end
    end
  end

endmodule : aer_first_bit

`default_nettype wire

// ===== hw/aer_error_regs.sv
`default_nettype none

// Operation
// R01 - Severity bit picks fatal or nonfatal message
// R02 - Severity register resets to 00030010h
// R03 - Severity bits 19 and 0 read zero
// R04 - Listed severity bits sticky, others reserved zero
// R05 - Replay timer expiry sets status bit 12
// R06 - Replay count wrap 11 to 00 sets 8
// R07 - Bad link packet CRC sets bit 7
// R08 - Bad transaction packet CRC sets bit 6
// R09 - Receiver error sets status bit 0
// R10 - Correctable status sticky, write one clears
// R11 - Sticky mask bit suppresses correctable message
// R12 - CRC capability and control bits read zero
// R13 - Pointer captures first uncorrectable error position
// R14 - Pointer holds, re-arms on named status clear
// R15 - Masked error skips report, log, pointer
// R16 - Header log locked until status cleared
// R17 - Armed after reset, lowest position wins
// R18 - Sticky bits cleared by cold reset only
module aer_error_regs #(
  parameter int AW = 12,
  parameter int DW = 32
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              warm_reset,
  input  wire logic [AW-1:0]     reg_addr,
  input  wire logic [DW-1:0]     reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DW-1:0]     reg_rdata,
  input  wire logic              replay_timer_expired,
  input  wire logic [1:0]        replay_num,
  input  wire logic              bad_link_packet,
  input  wire logic              bad_transaction_packet,
  input  wire logic              receiver_error,
  input  wire logic [31:0]       unc_error_event,
  input  wire logic [31:0]       unc_mask,
  input  wire logic [31:0]       unc_status_clear,
  output logic                   err_cor_msg,
  output logic                   err_nonfatal_msg,
  output logic                   err_fatal_msg,
  output logic                   header_log_capture,
  output logic                   header_log_locked,
  output logic                   irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Pointer width tracks the top bit of its field
  localparam int PTR_W = aer_pkg::PTR_MSB + 1;

  logic [31:0]               uncorrectable_severity;
  logic [31:0]               correctable_error_status;
  logic [31:0]               correctable_error_mask;
  logic [PTR_W-1:0]          first_error_pointer;
  logic                      pointer_armed;
  logic [PTR_W-1:0]          header_log_bit;
  logic [1:0]                replay_num_q;
  logic [aer_pkg::IRQ_W-1:0] irq_status;
  logic [aer_pkg::IRQ_W-1:0] irq_enable;

  logic [31:0]               cor_set;
  logic [31:0]               cor_clr;
  logic [31:0]               next_cor_status;
  logic [31:0]               unc_live;
  logic                      unc_any;
  logic [PTR_W-1:0]          unc_first;
  logic                      send_cor;
  logic                      send_fatal;
  logic                      send_nonfatal;
  logic [aer_pkg::IRQ_W-1:0] irq_set;
  logic [aer_pkg::IRQ_W-1:0] next_irq_status;
  logic                      wr_sev;
  logic                      wr_cor_sts;
  logic                      wr_cor_msk;
  logic                      wr_irq_en;
  logic                      rd_irq_sts;
  logic [31:0]               adv_cap_ctrl;
  logic [DW-1:0]             next_rdata;
  logic                      replay_wrap;
  logic                      pointer_rearm;
  logic                      header_unlock;
  logic [31:0]               unc_fatal;
  logic [31:0]               unc_nonfatal;
  logic                      next_irq;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  assign wr_sev     = reg_wr && (reg_addr == aer_pkg::OFS_UNC_SEVERITY);
  assign wr_cor_sts = reg_wr && (reg_addr == aer_pkg::OFS_COR_STATUS);
  assign wr_cor_msk = reg_wr && (reg_addr == aer_pkg::OFS_COR_MASK);
  assign wr_irq_en  = reg_wr && (reg_addr == aer_pkg::OFS_IRQ_ENABLE);
  assign rd_irq_sts = reg_rd && (reg_addr == aer_pkg::OFS_IRQ_STATUS);

  // ****************************************************************
  // Severity register
  // ****************************************************************
  // Only the implemented positions ever hold a one; 19 and 0 stay zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      uncorrectable_severity <= aer_pkg::SEV_RESET;  // see R02 see R18
    end else if (wr_sev) begin
      uncorrectable_severity <= reg_wdata[31:0] & aer_pkg::SEV_WRITABLE;  // see R03 see R04
    end
  end

  // ****************************************************************
  // Correctable error status
  // ****************************************************************
  always_comb begin
    cor_set = '0;
    cor_set[aer_pkg::COR_REPLAY_TIMEOUT]  = replay_timer_expired;  // see R05
    cor_set[aer_pkg::COR_REPLAY_ROLLOVER] = replay_wrap;  // see R06
    cor_set[aer_pkg::COR_BAD_LINK_PACKET] = bad_link_packet;  // see R07
    cor_set[aer_pkg::COR_BAD_TRANSACTION] = bad_transaction_packet;  // see R08
    cor_set[aer_pkg::COR_RECEIVER_ERROR]  = receiver_error;  // see R09
  end

  assign cor_clr         = wr_cor_sts ? (reg_wdata[31:0] & aer_pkg::COR_IMPL) : 32'h0000_0000;
  // A new event in the clearing cycle must not be lost
  assign next_cor_status = (correctable_error_status & ~cor_clr) | cor_set;  // see R10

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      correctable_error_status <= aer_pkg::COR_STATUS_RESET;  // see R18
    end else begin
      correctable_error_status <= next_cor_status;  // see R10
    end
  end

  // ****************************************************************
  // Replay count wrap
  // ****************************************************************
  // Previous replay count, for wrap detection; survives warm reset with the link
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      replay_num_q <= aer_pkg::REPLAY_NUM_BOT;
    end else begin
      replay_num_q <= replay_num;
    end
  end

  // Seen across two samples, so a count parked at zero never retriggers
  assign replay_wrap = (replay_num_q == aer_pkg::REPLAY_NUM_TOP) && (replay_num == aer_pkg::REPLAY_NUM_BOT);

  // ****************************************************************
  // Correctable error mask
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      correctable_error_mask <= aer_pkg::COR_MASK_RESET;  // see R11 see R18
    end else if (wr_cor_msk) begin
      correctable_error_mask <= reg_wdata[31:0] & aer_pkg::COR_IMPL;  // see R11
    end
  end

  // ****************************************************************
  // Uncorrectable events: first error pointer and header log lock
  // ****************************************************************
  // Masked sources still reach their status bits outside this block
  assign unc_live = unc_error_event & ~unc_mask & aer_pkg::UNC_IMPL;  // see R15

  aer_first_bit #(
    .W  (32),
    .IW (PTR_W)
  ) u_first (
    .vec   (unc_live),
    .found (unc_any),
    .index (unc_first)
  );

  // Clear pulses count only at the captured position
  assign pointer_rearm = !pointer_armed && unc_status_clear[first_error_pointer];
  assign header_unlock = header_log_locked && unc_status_clear[header_log_bit];

  // Re-arm only on clearing the named bit; value is kept either way
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      first_error_pointer <= '0;  // see R18
      pointer_armed       <= 1'b1;  // see R17
    end else if (pointer_armed) begin
      if (unc_any) begin
        first_error_pointer <= unc_first;  // see R13 see R17
        pointer_armed       <= 1'b0;
      end
    end else if (pointer_rearm) begin
      pointer_armed <= 1'b1;  // see R14
    end
  end

  // A masked source never reaches unc_any, so it cannot lock the log
  // Header log lock follows the same capture order as the pointer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      header_log_locked  <= 1'b0;
      header_log_bit     <= '0;
      header_log_capture <= 1'b0;
    end else if (!header_log_locked) begin
      header_log_capture <= unc_any;  // see R15
      if (unc_any) begin
        header_log_locked <= 1'b1;  // see R16
        header_log_bit    <= unc_first;
      end
    end else begin
      header_log_capture <= 1'b0;  // see R16
      if (header_unlock) begin
        header_log_locked <= 1'b0;  // see R16
      end
    end
  end

  // ****************************************************************
  // Error messages towards the host bridge
  // ****************************************************************
  // Severity splits each live source into exactly one class
  assign unc_fatal     = unc_live & uncorrectable_severity;  // see R01
  assign unc_nonfatal  = unc_live & ~uncorrectable_severity;  // see R01

  assign send_cor      = |(cor_set & ~correctable_error_mask);  // see R11
  assign send_fatal    = |unc_fatal;  // see R01
  assign send_nonfatal = |unc_nonfatal;  // see R01

  // One-cycle pulses; a warm reset drops a message in flight
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_cor_msg      <= 1'b0;
      err_fatal_msg    <= 1'b0;
      err_nonfatal_msg <= 1'b0;
    end else if (warm_reset) begin
      err_cor_msg      <= 1'b0;
      err_fatal_msg    <= 1'b0;
      err_nonfatal_msg <= 1'b0;
    end else begin
      err_cor_msg      <= send_cor;
      err_fatal_msg    <= send_fatal;
      err_nonfatal_msg <= send_nonfatal;
    end
  end

  // ****************************************************************
  // Interrupt status and enable
  // ****************************************************************
  always_comb begin
    irq_set                        = '0;
    irq_set[aer_pkg::IRQ_COR]      = send_cor;
    irq_set[aer_pkg::IRQ_NONFATAL] = send_nonfatal;
    irq_set[aer_pkg::IRQ_FATAL]    = send_fatal;
  end

  // Read clears, but an event in the same cycle survives the read
  assign next_irq_status = (rd_irq_sts ? aer_pkg::IRQ_RESET : irq_status) | irq_set;

  // Not sticky: a warm reset clears the interrupt path
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= aer_pkg::IRQ_RESET;
    end else if (warm_reset) begin
      irq_status <= aer_pkg::IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_enable <= aer_pkg::IRQ_RESET;
    end else if (warm_reset) begin
      irq_enable <= aer_pkg::IRQ_RESET;
    end else if (wr_irq_en) begin
      irq_enable <= reg_wdata[aer_pkg::IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // Interrupt pin
  // ****************************************************************
  // An enable write reaches the pin together with the register
  always_comb begin
    if (wr_irq_en) begin
      next_irq = |(next_irq_status & reg_wdata[aer_pkg::IRQ_W-1:0]);
    end else begin
      next_irq = |(next_irq_status & irq_enable);
    end
  end

  // Registered from next state so the pin tracks status without extra lag
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else if (warm_reset) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // CRC enable and capability bits are tied low; generation writes ignored
  always_comb begin
    adv_cap_ctrl                            = '0;
    adv_cap_ctrl[aer_pkg::CRC_CHECK_ENABLE]  = 1'b0;  // see R12
    adv_cap_ctrl[aer_pkg::CRC_CHECK_CAPABLE] = 1'b0;  // see R12
    adv_cap_ctrl[aer_pkg::CRC_GEN_ENABLE]    = 1'b0;  // see R12
    adv_cap_ctrl[aer_pkg::CRC_GEN_CAPABLE]   = 1'b0;  // see R12
    adv_cap_ctrl[aer_pkg::PTR_MSB:0]         = first_error_pointer;  // see R13
  end

  always_comb begin
    next_rdata = '0;
    case (reg_addr)
      aer_pkg::OFS_UNC_SEVERITY: next_rdata = DW'(uncorrectable_severity);
      aer_pkg::OFS_COR_STATUS:   next_rdata = DW'(correctable_error_status);
      aer_pkg::OFS_COR_MASK:     next_rdata = DW'(correctable_error_mask);
      aer_pkg::OFS_ADV_CAP_CTRL: next_rdata = DW'(adv_cap_ctrl);
      aer_pkg::OFS_IRQ_STATUS:   next_rdata = DW'(irq_status);
      aer_pkg::OFS_IRQ_ENABLE:   next_rdata = DW'(irq_enable);
      default:                   next_rdata = '0;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : aer_error_regs

`default_nettype wire

// ===== tb/aer_host_model.sv
`default_nettype none

// ****************************************************************
// Upstream message sink
// ****************************************************************
module aer_host_model (
  input  wire logic        ref_clk,
  input  wire logic        err_cor_msg,
  input  wire logic        err_nonfatal_msg,
  input  wire logic        err_fatal_msg,
  output logic      [31:0] cor_count,
  output logic      [31:0] nonfatal_count,
  output logic      [31:0] fatal_count
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bridge keeps its tally across device resets
  initial begin
    cor_count = 32'h0;
    nonfatal_count = 32'h0;
    fatal_count = 32'h0;
  end

  always @(posedge ref_clk) begin
    if (err_cor_msg === 1'b1) cor_count <= cor_count + 32'h1;
    if (err_nonfatal_msg === 1'b1) nonfatal_count <= nonfatal_count + 32'h1;
    if (err_fatal_msg === 1'b1) fatal_count <= fatal_count + 32'h1;
  end
endmodule : aer_host_model

`default_nettype wire

// ===== tb/aer_error_regs_properties.sv
`default_nettype none

// ****************************************************************
// Port checker
// ****************************************************************
module aer_error_regs_checker (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        warm_reset,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        replay_timer_expired,
  input  wire logic [1:0]  replay_num,
  input  wire logic        bad_link_packet,
  input  wire logic        bad_transaction_packet,
  input  wire logic        receiver_error,
  input  wire logic [31:0] unc_error_event,
  input  wire logic [31:0] unc_mask,
  input  wire logic [31:0] unc_status_clear,
  input  wire logic        err_cor_msg,
  input  wire logic        err_nonfatal_msg,
  input  wire logic        err_fatal_msg,
  input  wire logic        header_log_capture,
  input  wire logic        header_log_locked,
  input  wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  logic [31:0] live;
  logic        cor_any;
  assign live = unc_error_event & ~unc_mask;
  assign cor_any = replay_timer_expired | bad_link_packet | bad_transaction_packet | receiver_error;

  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  cor_cause_a: assert property (err_cor_msg |-> $past(cor_any) ||
    ($past(replay_num, 2) == 2'h3 && $past(replay_num) == 2'h0))
    else $error("correctable message without event");
  unc_cause_a: assert property ((err_fatal_msg || err_nonfatal_msg) |-> $past(|live))
    else $error("uncorrectable message without unmasked event");
  masked_quiet_a: assert property (live == 32'h0 |=> !err_fatal_msg && !err_nonfatal_msg && !header_log_capture)
    else $error("masked or absent event reported");
  capture_msg_a: assert property (header_log_capture |-> (err_fatal_msg || err_nonfatal_msg) && header_log_locked)
    else $error("header capture without message or lock");
  locked_refuse_a: assert property (header_log_locked && unc_status_clear == 32'h0 |=> !header_log_capture)
    else $error("header captured while locked");
  lock_holds_a: assert property (header_log_locked && unc_status_clear == 32'h0 |=> header_log_locked)
    else $error("header lock dropped without clear");
  irq_cause_a: assert property ($rose(irq) && !$past(reg_wr) && !$past(reg_wr, 2) |->
    err_cor_msg || err_nonfatal_msg || err_fatal_msg)
    else $error("interrupt rose without message");
  warm_quiet_a: assert property (warm_reset |=> !irq && !err_cor_msg && !err_fatal_msg)
    else $error("warm reset left interrupt or message");

  cov_cor_c: cover property (err_cor_msg);
  cov_fatal_c: cover property (err_fatal_msg);
  cov_lock_c: cover property (header_log_locked && |unc_status_clear);
endmodule : aer_error_regs_checker

bind aer_error_regs aer_error_regs_checker chk_u (.ref_clk, .arst_n, .warm_reset, .reg_wr, .reg_rd,
  .reg_rdata, .replay_timer_expired, .replay_num, .bad_link_packet, .bad_transaction_packet,
  .receiver_error, .unc_error_event, .unc_mask, .unc_status_clear, .err_cor_msg, .err_nonfatal_msg,
  .err_fatal_msg, .header_log_capture, .header_log_locked, .irq);

`default_nettype wire

// ===== tb/test_pcie_error_severity_and_correctable_log.sv
`default_nettype none

module test_pcie_error_severity_and_correctable_log;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e;} aer_row_s;

  logic ref_clk, arst_n, warm_reset, reg_wr, reg_rd, replay_timer_expired;
  logic bad_link_packet, bad_transaction_packet, receiver_error;
  logic err_cor_msg, err_nonfatal_msg, err_fatal_msg, header_log_capture, header_log_locked, irq;
  logic [11:0] reg_addr;
  logic [1:0]  replay_num;
  logic [31:0] reg_wdata, reg_rdata, unc_error_event, unc_mask, unc_status_clear;
  logic [31:0] cor_n, nf_n, fat_n, err_count, cmp_count;
  aer_row_s    rows [9];

  aer_error_regs dut_u (.ref_clk, .arst_n, .warm_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .replay_timer_expired, .replay_num, .bad_link_packet, .bad_transaction_packet,
    .receiver_error, .unc_error_event, .unc_mask, .unc_status_clear, .err_cor_msg,
    .err_nonfatal_msg, .err_fatal_msg, .header_log_capture, .header_log_locked, .irq);
  aer_host_model host_u (.ref_clk, .err_cor_msg, .err_nonfatal_msg, .err_fatal_msg,
    .cor_count(cor_n), .nonfatal_count(nf_n), .fatal_count(fat_n));

  task complete_run;
    if (err_count == 32'h0 && cmp_count != 32'h0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    cmp_count = cmp_count + 32'h1;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      err_count = err_count + 32'h1;
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask : rd

  // One-cycle pulse of correctable sources, unc events and unc clears
  task ev(input logic [3:0] c, input logic [31:0] u, input logic [31:0] k);
    @(posedge ref_clk) begin
      {replay_timer_expired, bad_link_packet, bad_transaction_packet, receiver_error} <= c;
      unc_error_event <= u;
      unc_status_clear <= k;
    end
    @(posedge ref_clk) begin
      {replay_timer_expired, bad_link_packet, bad_transaction_packet, receiver_error} <= 4'h0;
      unc_error_event <= 32'h0;
      unc_status_clear <= 32'h0;
    end
    #1;
  endtask : ev

  task counts(input logic [31:0] c, input logic [31:0] nf, input logic [31:0] f);
    // Host tallies one edge after the message pulse
    repeat (2) @(posedge ref_clk);
    #1;
    chk("cor_count", cor_n, c);
    chk("nonfatal_count", nf_n, nf);
    chk("fatal_count", fat_n, f);
  endtask : counts

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count = err_count + 32'h1;
    complete_run();
  end

  initial begin
    {arst_n, warm_reset, reg_wr, reg_rd, replay_timer_expired, bad_link_packet} = 6'h0;
    {bad_transaction_packet, receiver_error, reg_addr, replay_num} = 16'h0;
    {reg_wdata, unc_error_event, unc_mask, unc_status_clear} = 128'h0;
    {err_count, cmp_count} = 64'h0;
    rows = '{'{12'h10C, 1'b0, 32'h0, 32'h0003_0010}, '{12'h10C, 1'b1, 32'hFFFF_FFFF, 32'h0017_F010},
      '{12'h10C, 1'b1, 32'h0, 32'h0}, '{12'h114, 1'b1, 32'hFFFF_FFFF, 32'h0000_11C1},
      '{12'h114, 1'b1, 32'h0, 32'h0}, '{12'h118, 1'b1, 32'hFFFF_FFFF, 32'h0},
      '{12'h110, 1'b1, 32'hFFFF_FFFF, 32'h0}, '{12'h100, 1'b1, 32'hFFFF_FFFF, 32'h0},
      '{12'h10C, 1'b1, 32'h0003_0010, 32'h0003_0010}};
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // ****************************************************************
    // Correctable sources, interrupt, write-one-clear
    // ****************************************************************
    wr(12'h144, 32'h7);
    ev(4'hF, 32'h0, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    @(posedge ref_clk) replay_num <= 2'h3;
    @(posedge ref_clk) replay_num <= 2'h0;
    counts(32'h2, 32'h0, 32'h0);
    rd(12'h110, 32'h0000_11C1);
    rd(12'h140, 32'h1);
    rd(12'h140, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(12'h110, 32'h80);
    rd(12'h110, 32'h0000_1141);
    wr(12'h110, 32'h0);
    rd(12'h110, 32'h0000_1141);
    wr(12'h110, 32'h0000_1141);
    rd(12'h110, 32'h0);
    wr(12'h114, 32'h80);
    ev(4'h4, 32'h0, 32'h0);
    counts(32'h2, 32'h0, 32'h0);
    ev(4'h2, 32'h0, 32'h0);
    counts(32'h3, 32'h0, 32'h0);
    // ****************************************************************
    // Uncorrectable severity, pointer and header lock
    // ****************************************************************
    ev(4'h0, 32'h0000_6000, 32'h0);
    counts(32'h3, 32'h1, 32'h0);
    rd(12'h118, 32'h0000_000D);
    ev(4'h0, 32'h0002_0000, 32'h0);
    counts(32'h3, 32'h1, 32'h1);
    rd(12'h118, 32'h0000_000D);
    chk("header_log_locked", {31'h0, header_log_locked}, 32'h1);
    ev(4'h0, 32'h0, 32'h0000_2000);
    chk("header_log_locked", {31'h0, header_log_locked}, 32'h0);
    rd(12'h118, 32'h0000_000D);
    unc_mask <= 32'h0001_0000;
    ev(4'h0, 32'h0001_0000, 32'h0);
    counts(32'h3, 32'h1, 32'h1);
    rd(12'h118, 32'h0000_000D);
    unc_mask <= 32'h0;
    ev(4'h0, 32'h0004_0000, 32'h0);
    rd(12'h118, 32'h0000_0012);
    wr(12'h10C, 32'h0);
    ev(4'h0, 32'h0002_0000, 32'h0);
    counts(32'h3, 32'h3, 32'h1);
    // ****************************************************************
    // Warm reset keeps sticky state, cold reset clears it
    // ****************************************************************
    @(posedge ref_clk) warm_reset <= 1'b1;
    @(posedge ref_clk) warm_reset <= 1'b0;
    rd(12'h118, 32'h0000_0012);
    rd(12'h110, 32'h0000_00C0);
    rd(12'h114, 32'h80);
    rd(12'h144, 32'h0);
    @(posedge ref_clk) arst_n <= 1'b0;
    @(posedge ref_clk) arst_n <= 1'b1;
    rd(12'h10C, 32'h0003_0010);
    rd(12'h118, 32'h0);
    complete_run();
  end
endmodule : test_pcie_error_severity_and_correctable_log

`default_nettype wire
